// ===== dmcd_decoder.sv
/*
 * Display module command decoder: executes parsed bus commands addressed
 * to this module and holds the display registers and flags.
 * Assumes a parser on the same clock hands over one command per strobe,
 * and that the address switches are static pins (synchronised here).
 */
// Contract
// - all control arrives only as commands from the bus
// - address comes from rear switches, valid range 1 to 31
// - load command stores operand into the numbered register
// - set command turns the numbered flag on
// - clear command turns the numbered flag off
// - register 0 display value, 0..65535, reset 0, write-only
// - register 1 decimal places 0..5, reset 0, write-only
// - registers 10..25 are mailboxes, readable and writable, reset 0
// - flags 2..5 light plus, minus, leading one, bar symbols
// - flag 7 lights decimal point, defaults on
// - flags 21..29 select fixed text messages, default off
// - flag 30 forces display test, default off
// - register 0 shown on five-digit display
// - register 1 gives decimal places, zero means no point
// - uninterpretable or unexecutable command sends an error reply
// - unknown operation or register gives error type 3
module dmcd_decoder
  import dmcd_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // address switches
  input wire logic [4:0] i_addr_sw,
  // parsed command
  input wire logic i_cmd_valid,
  input wire logic [1:0] i_cmd_op,
  input wire logic [4:0] i_cmd_addr,
  input wire logic [7:0] i_cmd_num,
  input wire logic [15:0] i_cmd_operand,
  // reply to controller
  output logic o_rsp_valid,
  output logic [1:0] o_rsp_err,
  output logic [15:0] o_rsp_data,
  // display state
  output logic [15:0] o_display_value,
  output logic [2:0] o_decimal_places,
  output logic [SYM_COUNT-1:0] o_symbols,
  output logic o_signed_en,
  output logic o_point_en,
  output logic [TEXT_COUNT-1:0] o_text_sel,
  output logic o_test_en
);
  logic [4:0] addr_meta_r;
  logic [4:0] addr_r;
  logic [15:0] mailbox_r [16];
  logic [3:0] mb_idx;
  logic hit;
  logic is_mb;
  logic is_sym;
  logic is_text;
  logic flag_ok;
  logic load_ok;
  logic soft_rst;
  logic [1:0] err_nxt;
  logic [1:0] sym_idx;
  logic [3:0] text_idx;
  logic flag_wr;
  logic flag_val;

  // switches are pins: two flops before use
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_meta_r <= 5'h00;
      addr_r <= 5'h00;
    end else begin
      addr_meta_r <= i_addr_sw;
      addr_r <= addr_meta_r;
    end
  end

  // address 0 is outside the switch range, so it never matches
  assign hit = i_cmd_valid && addr_r >= ADDR_MIN && i_cmd_addr == addr_r;
  assign is_mb = i_cmd_num >= REG_MAILBOX_FIRST && i_cmd_num <= REG_MAILBOX_LAST;
  assign mb_idx = 4'(i_cmd_num - REG_MAILBOX_FIRST);
  assign is_sym = i_cmd_num >= FLAG_SYM_FIRST && i_cmd_num < FLAG_SIGNED;
  assign sym_idx = 2'(i_cmd_num - FLAG_SYM_FIRST);
  assign is_text = i_cmd_num >= FLAG_TEXT_FIRST && i_cmd_num <= FLAG_TEXT_LAST;
  assign text_idx = 4'(i_cmd_num - FLAG_TEXT_FIRST);
  assign flag_ok = i_cmd_num == FLAG_RESET_ALL || is_sym || i_cmd_num == FLAG_SIGNED
                   || i_cmd_num == FLAG_POINT_ON || is_text || i_cmd_num == FLAG_TEST;
  // the other loadable registers are 16 bits wide, so only decimal places can overflow
  assign load_ok = i_cmd_num == REG_DISPLAY_VALUE || is_mb
                   || (i_cmd_num == REG_DECIMAL_PLACES
                       && i_cmd_operand <= DECIMAL_PLACES_MAX);
  // reset-all acts on the set command and does not stay latched
  assign soft_rst = hit && i_cmd_op == OP_SET && i_cmd_num == FLAG_RESET_ALL;
  // flag 1 only drives the soft reset; no flop below decodes it
  assign flag_wr = hit && (i_cmd_op == OP_SET || i_cmd_op == OP_CLEAR);
  assign flag_val = i_cmd_op == OP_SET;

  always_comb begin
    err_nxt = ERR_NONE;
    unique case (i_cmd_op)
      OP_LOAD: if (!load_ok) err_nxt = ERR_UNKNOWN;
      OP_SET, OP_CLEAR: if (!flag_ok) err_nxt = ERR_UNKNOWN;
      OP_READ: if (!is_mb) err_nxt = ERR_UNKNOWN;
    endcase
  end

  // every addressed command gets a one-cycle reply strobe
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rsp_valid <= 1'b0;
    end else begin
      o_rsp_valid <= hit;
    end
  end

  // error code 0 means done; code and data hold until the next reply
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rsp_err <= ERR_NONE;
      o_rsp_data <= VALUE_RESET;
    end else if (hit) begin
      o_rsp_err <= err_nxt;
      o_rsp_data <= (i_cmd_op == OP_READ && is_mb) ? mailbox_r[mb_idx] : VALUE_RESET;
    end
  end

  // display value and decimal places
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_display_value <= VALUE_RESET;
      o_decimal_places <= 3'h0;
    end else if (soft_rst) begin
      o_display_value <= VALUE_RESET;
      o_decimal_places <= 3'h0;
    end else if (hit && i_cmd_op == OP_LOAD && load_ok) begin
      if (i_cmd_num == REG_DISPLAY_VALUE) o_display_value <= i_cmd_operand;
      if (i_cmd_num == REG_DECIMAL_PLACES) o_decimal_places <= i_cmd_operand[2:0];
    end
  end

  // mailbox bank
  // no display use; controllers pass data to each other here
  for (genvar g = 0; g < 16; g++) begin : g_mb
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        mailbox_r[g] <= VALUE_RESET;
      end else if (soft_rst) begin
        mailbox_r[g] <= VALUE_RESET;
      end else if (hit && i_cmd_op == OP_LOAD && is_mb && mb_idx == 4'(g)) begin
        mailbox_r[g] <= i_cmd_operand;
      end
    end
  end

  // symbol flags, one flop per symbol
  for (genvar s = 0; s < SYM_COUNT; s++) begin : g_sym
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_symbols[s] <= 1'b0;
      end else if (soft_rst) begin
        o_symbols[s] <= 1'b0;
      end else if (flag_wr && is_sym && sym_idx == 2'(s)) begin
        o_symbols[s] <= flag_val;
      end
    end
  end

  // text flags are independent; more than one may be on at once
  for (genvar t = 0; t < TEXT_COUNT; t++) begin : g_text
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_text_sel[t] <= 1'b0;
      end else if (soft_rst) begin
        o_text_sel[t] <= 1'b0;
      end else if (flag_wr && is_text && text_idx == 4'(t)) begin
        o_text_sel[t] <= flag_val;
      end
    end
  end

  // signed display function
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_signed_en <= 1'b0;
    end else if (soft_rst) begin
      o_signed_en <= 1'b0;
    end else if (flag_wr && i_cmd_num == FLAG_SIGNED) begin
      o_signed_en <= flag_val;
    end
  end

  // decimal point is the only flag that comes up on
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_point_en <= 1'b1;
    end else if (soft_rst) begin
      o_point_en <= 1'b1;
    end else if (flag_wr && i_cmd_num == FLAG_POINT_ON) begin
      o_point_en <= flag_val;
    end
  end

  // display test pattern
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_test_en <= 1'b0;
    end else if (soft_rst) begin
      o_test_en <= 1'b0;
    end else if (flag_wr && i_cmd_num == FLAG_TEST) begin
      o_test_en <= flag_val;
    end
  end
endmodule : dmcd_decoder

// ===== dmcd_pkg.sv
/*
 * Shared constants for the display module command decoder: command
 * opcodes, register numbers, flag numbers, ranges, reset values.
 * Assumes a character-level front end has already parsed bus frames.
 */
package dmcd_pkg;
  // command opcodes delivered by the frame parser
  localparam logic [1:0] OP_LOAD = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLEAR = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  // register numbers
  localparam logic [7:0] REG_DISPLAY_VALUE = 8'h00;
  localparam logic [7:0] REG_DECIMAL_PLACES = 8'h01;
  localparam logic [7:0] REG_MAILBOX_FIRST = 8'h0A;
  localparam logic [7:0] REG_MAILBOX_LAST = 8'h19;
  localparam logic [15:0] DECIMAL_PLACES_MAX = 16'h0005;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // flag numbers
  localparam logic [7:0] FLAG_RESET_ALL = 8'h01;
  localparam logic [7:0] FLAG_SYM_FIRST = 8'h02;
  localparam logic [7:0] FLAG_SIGNED = 8'h06;
  localparam logic [7:0] FLAG_POINT_ON = 8'h07;
  localparam logic [7:0] FLAG_TEXT_FIRST = 8'h15;
  localparam logic [7:0] FLAG_TEXT_LAST = 8'h1D;
  localparam logic [7:0] FLAG_TEST = 8'h1E;
  localparam int SYM_COUNT = 4;
  localparam int TEXT_COUNT = 9;
  // address range and error codes
  localparam logic [4:0] ADDR_MIN = 5'h01;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_UNKNOWN = 2'h3;
endpackage : dmcd_pkg

// ===== dmcd_monitor.sv
/* port checker for the display command decoder.
   assumes a bind onto dmcd_decoder, one clock, async active-low reset. */
module dmcd_monitor
  import dmcd_pkg::*;
(
  input wire logic i_ref_clk, input wire logic i_arst_n, input wire logic [4:0] i_addr_sw,
  input wire logic i_cmd_valid, input wire logic [1:0] i_cmd_op,
  input wire logic [4:0] i_cmd_addr, input wire logic [7:0] i_cmd_num,
  input wire logic [15:0] i_cmd_operand, input wire logic o_rsp_valid,
  input wire logic [1:0] o_rsp_err, input wire logic [15:0] o_display_value,
  input wire logic [2:0] o_decimal_places, input wire logic o_point_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] sw1_r, sw2_r;
  logic tk;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) {sw1_r, sw2_r} <= 10'h000;
    else {sw2_r, sw1_r} <= {sw1_r, i_addr_sw};
  end
  // zero while switches settle, so nothing matches
  assign tk = i_cmd_valid && i_cmd_addr == sw2_r && sw2_r != 5'h00;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_load(n);
    tk && i_cmd_op == OP_LOAD && i_cmd_num == n;
  endsequence
  reply_timing_a: assert property (tk |=> o_rsp_valid)
    else $error("no reply after a taken command");
  foreign_quiet_a: assert property (!tk |=> !o_rsp_valid && $stable(o_display_value))
    else $error("reply or change without a matching command");
  display_load_a: assert property (s_load(REG_DISPLAY_VALUE) |=>
    o_display_value == $past(i_cmd_operand) && o_rsp_err == ERR_NONE) else $error("bad load");
  point_load_a: assert property (s_load(REG_DECIMAL_PLACES) ##0
    (i_cmd_operand <= DECIMAL_PLACES_MAX) |=> o_decimal_places == $past(i_cmd_operand[2:0]))
    else $error("decimal places not loaded");
  point_refuse_a: assert property (s_load(REG_DECIMAL_PLACES) ##0
    (i_cmd_operand > DECIMAL_PLACES_MAX) |=> o_rsp_err == ERR_UNKNOWN && $stable(o_decimal_places))
    else $error("out of range load not refused");
  read_refuse_a: assert property (tk && i_cmd_op == OP_READ &&
    !(i_cmd_num inside {[REG_MAILBOX_FIRST:REG_MAILBOX_LAST]}) |=> o_rsp_err == ERR_UNKNOWN)
    else $error("read of non-mailbox not refused");
  point_clear_a: assert property (tk && i_cmd_op == OP_CLEAR &&
    i_cmd_num == FLAG_POINT_ON |=> !o_point_en) else $error("point flag not cleared");
  point_default_a: assert property ($rose(i_arst_n) |-> o_point_en)
    else $error("point flag off after reset");
  places_bound_a: assert property (o_decimal_places <= 3'h5)
    else $error("decimal places above five");
endmodule : dmcd_monitor

// ===== dmcd_ctrl_model.sv
/* controller model: sends one parsed command per strobe.
   assumes the bench calls send and that it is the only sender on the bus. */
module dmcd_ctrl_model
(
  input wire logic i_ref_clk,
  output logic o_cmd_valid, output logic [1:0] o_cmd_op, output logic [4:0] o_cmd_addr,
  output logic [7:0] o_cmd_num, output logic [15:0] o_cmd_operand
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_cmd_valid, o_cmd_op, o_cmd_addr, o_cmd_num, o_cmd_operand} = '0;
  // one module, one address on this bus; operand already resolved
  task automatic send(input logic [1:0] op, input logic [4:0] a, input logic [7:0] n,
    input logic [15:0] v);
    @(posedge i_ref_clk);
    {o_cmd_valid, o_cmd_op, o_cmd_addr, o_cmd_num, o_cmd_operand} <= {1'b1, op, a, n, v};
    @(posedge i_ref_clk);
    // released fields must not look like a held command
    {o_cmd_valid, o_cmd_num, o_cmd_operand} <= {1'b0, ~n, ~v};
  endtask : send
endmodule : dmcd_ctrl_model

// ===== display_module_command_decoder_tb_top.sv
/* self-checking bench with an integer model of the decoder.
   assumes the decoder, controller model and monitor are compiled first. */
module display_module_command_decoder_tb_top
  import dmcd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [4:0] i_addr_sw = 5'h03;
  logic i_cmd_valid, o_rsp_valid, o_signed_en, o_point_en, o_test_en;
  logic [1:0] i_cmd_op, o_rsp_err;
  logic [4:0] i_cmd_addr;
  logic [7:0] i_cmd_num;
  logic [15:0] i_cmd_operand, o_rsp_data, o_display_value;
  logic [2:0] o_decimal_places;
  logic [3:0] o_symbols;
  logic [8:0] o_text_sel;
  logic [31:0] fl;
  int n_mismatch = 0, n_compared = 0, disp, dp, mb[32];
  dmcd_decoder u_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr_sw(i_addr_sw),
    .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
    .i_cmd_num(i_cmd_num), .i_cmd_operand(i_cmd_operand), .o_rsp_valid(o_rsp_valid),
    .o_rsp_err(o_rsp_err), .o_rsp_data(o_rsp_data), .o_display_value(o_display_value),
    .o_decimal_places(o_decimal_places), .o_symbols(o_symbols), .o_signed_en(o_signed_en),
    .o_point_en(o_point_en), .o_text_sel(o_text_sel), .o_test_en(o_test_en));
  dmcd_ctrl_model u_ctrl (.i_ref_clk(i_ref_clk), .o_cmd_valid(i_cmd_valid), .o_cmd_op(i_cmd_op),
    .o_cmd_addr(i_cmd_addr), .o_cmd_num(i_cmd_num), .o_cmd_operand(i_cmd_operand));
  initial forever #10 i_ref_clk = ~i_ref_clk;
  initial begin
    #50us;
    n_mismatch++;
    print_verdict();
  end
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [15:0] got, input int exp_v);
    n_compared++;
    if (got !== 16'(exp_v)) begin
      n_mismatch++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, 16'(exp_v));
    end
  endtask : cmp
  task automatic chk_rsp(input bit want, input int e, input int d);
    cmp(16'(o_rsp_valid), int'(want));
    if (want) begin
      cmp(16'(o_rsp_err), e);
      cmp(o_rsp_data, d);
    end
  endtask : chk_rsp
  task automatic chk_state();
    cmp(o_display_value, disp);
    cmp(16'(o_decimal_places), dp);
    cmp({o_test_en, o_text_sel, o_point_en, o_signed_en, o_symbols},
      {fl[30:21], fl[7:2]});
  endtask : chk_state
  function automatic void init();
    {disp, dp, fl} = {32'h0, 32'h0, 32'h80};
    mb = '{default: 0};
  endfunction : init
  task automatic run(input logic [1:0] op, input int n, input int v, input logic [4:0] a);
    int e = 3;
    int d = 0;
    u_ctrl.send(op, a, 8'(n), 16'(v));
    if (a == i_addr_sw) begin
      if (op == OP_LOAD && (n == 0 || n inside {[10:25]} || n == 1 && v <= 5)) begin
        e = 0;
        if (n == 0) disp = v; else if (n == 1) dp = v; else mb[n] = v;
      end else if (op == OP_READ && n inside {[10:25]}) begin
        {e, d} = {32'h0, mb[n]};
      end else if (op inside {OP_SET, OP_CLEAR} && n inside {[1:7], [21:30]}) begin
        e = 0;
        if (n == 1 && op == OP_SET) init(); else if (n != 1) fl[n] = op == OP_SET;
      end
    end
    #1;
    chk_rsp(a == i_addr_sw, e, d);
    chk_state();
  endtask : run
  initial begin
    void'($urandom(32'h8B82D62B));
    init();
    repeat (2) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    #1;
    chk_state();
    repeat (2) @(posedge i_ref_clk);
    $display("test reset done");
    for (int n = 0; n < 28; n++) run(OP_LOAD, n, $urandom_range(n == 1 ? 7 : 65535), 5'h03);
    for (int n = 6; n >= 5; n--) run(OP_LOAD, 1, n, 5'h03);
    for (int n = 0; n < 28; n++) run(OP_READ, n, 0, 5'h03);
    $display("test registers done");
    for (int n = 2; n < 32; n++) run(OP_SET, n, 0, 5'h03);
    for (int n = 0; n < 32; n++) run(OP_CLEAR, n, 0, 5'h03);
    run(OP_SET, 1, 0, 5'h03);
    run(OP_READ, 12, 0, 5'h03);
    run(OP_CLEAR, 7, 0, 5'h03);
    run(OP_LOAD, 12, 16'h1234, 5'h03);
    @(posedge i_ref_clk);
    i_arst_n <= 1'b0;
    @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    init();
    #1;
    chk_state();
    repeat (2) @(posedge i_ref_clk);
    run(OP_READ, 12, 0, 5'h03);
    $display("test flags done");
    repeat (60) run(2'($urandom_range(3)), $urandom_range(31), $urandom_range(65535),
      $urandom_range(1) ? 5'h03 : 5'($urandom_range(31)));
    $display("test random done");
    print_verdict();
  end
endmodule : display_module_command_decoder_tb_top
bind dmcd_decoder dmcd_monitor u_mon (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
  .i_addr_sw(i_addr_sw), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
  .i_cmd_addr(i_cmd_addr), .i_cmd_num(i_cmd_num), .i_cmd_operand(i_cmd_operand),
  .o_rsp_valid(o_rsp_valid), .o_rsp_err(o_rsp_err), .o_display_value(o_display_value),
  .o_decimal_places(o_decimal_places), .o_point_en(o_point_en));
